// ===== hw/seq_consts.svh
/*
  timing constants for the supply fault sequencer.
  assumes a 100 MHz system clock; counts derive from times in ns.
*/
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH
`define CLK_PERIOD_NS 10
`define SOFT_START_NS 1400000
`define SOFT_STOP_NS 2800000
`define TERM_RAMP_NS 160000
`define UV_PERSIST_NS 200000
`define TERM_PERSIST_NS 5000000
`define SOFT_START_CYC (`SOFT_START_NS / `CLK_PERIOD_NS)
`define SOFT_STOP_CYC (`SOFT_STOP_NS / `CLK_PERIOD_NS)
`define TERM_RAMP_CYC (`TERM_RAMP_NS / `CLK_PERIOD_NS)
`define UV_PERSIST_CYC (`UV_PERSIST_NS / `CLK_PERIOD_NS)
`define TERM_PERSIST_CYC (`TERM_PERSIST_NS / `CLK_PERIOD_NS)
`define RAMP_W 8
`define RAMP_FULL 8'hFF
`endif

// ===== hw/seq_pkg.sv
/*
  types for the supply fault sequencer.
  assumes seq_consts.svh defines the widths.
*/
`include "seq_consts.svh"
package seq_pkg;
  typedef enum logic [2:0] {
    st_off, st_wait_bias, st_soft_start, st_run, st_soft_stop, st_latched
  } seq_state_t;
  // comparator results, all already synchronised
  typedef struct packed {
    logic valley_over;   // inductor current above valley limit
    logic negative_over; // reverse current beyond negative limit
    logic main_in_window;
    logic main_over;
    logic main_under;
    logic term_in_window;
    logic thermal;
  } sense_t;
  // gate and enable outputs
  typedef struct packed {
    logic high_side_gate;
    logic low_side_gate;
    logic main_output_good_flag_oe;
    logic term_output_good_flag_oe;
    logic term_enable;
    logic ref_enable;
    logic main_discharge;
    logic term_discharge;
    logic pulse_skip;
    logic switch_allow;
  } drive_t;
endpackage

// ===== hw/ramp_counter.sv
/*
  ramp_counter: a cycle counter that reports done after a set count, plus
  a linear level of RAMP_W bits scaled to the progress.
  assumes one clock domain; start restarts, clear stops and zeroes.
*/
`timescale 1ns/1ns
`include "seq_consts.svh"
module ramp_counter #(
  parameter int unsigned COUNT = 1000,
  parameter int unsigned W = 32
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // control
  input wire logic start,
  input wire logic clear,
  // status
  output logic done,
  output logic [`RAMP_W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic run;
    logic done;
    logic [`RAMP_W-1:0] level;
  } rc_state_t;
  rc_state_t s_q, s_d;
  logic [W+`RAMP_W-1:0] scaled; // progress times full scale

  // next state; level is cnt scaled to 8 bits
  always_comb begin
    s_d = s_q;
    scaled = (W+`RAMP_W)'(s_q.cnt) * (W+`RAMP_W)'(`RAMP_FULL);
    if (clear) begin
      s_d = '0;
    end else if (start) begin
      s_d.cnt = '0;
      s_d.run = 1'b1;
      s_d.done = 1'b0;
      s_d.level = '0;
    end else if (s_q.run) begin
      s_d.level = `RAMP_W'(scaled / (W+`RAMP_W)'(COUNT));
      if (s_q.cnt >= W'(COUNT - 1)) begin
        s_d.run = 1'b0;
        s_d.done = 1'b1;
        s_d.level = `RAMP_FULL;
      end else begin
        s_d.cnt = s_q.cnt + W'(1);
      end
    end
  end

  // state register, frozen while clk_en is low
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
  assign level = s_q.level;
endmodule

// ===== hw/ddr_supply_fault_sequencer.sv
/*
  ddr_supply_fault_sequencer: sequencing and fault supervision for a memory
  supply controller (main buck, termination regulator, reference buffer).
  assumes comparator results and selects arrive as pins from the analog side
  and are synchronised here; open-drain flags are given as output enables.
*/
// Functional notes
// - no new high-side cycle above valley limit, except in soft-stop on run or thermal
// - negative current limit only in forced continuous
// - main good flag low in off and ramps
// - main good flag follows window after soft-start
// - latched fault holds off until run toggles
// - overvoltage drops main flag; unprotected keeps running
// - term flag low in standby, off, soft-start
// - term flag follows plus-minus ten percent window
// - term flag low 5ms latches fault, soft-stop
// - power-on reset clears latch and soft-start
// - power-on reset edge discharges if protected
// - no switching until bias lockout clears
// - lockout fall: gates low, flags low, off
// - run rising starts 1.4ms soft-start ramp
// - startup pulse-skips; selects apply after soft-start
// - term current limit ramps over 160us
// - reference buffer enabled at once; its target tracks the soft-start ramp
// - soft-stop on undervolt, term fault, thermal, run
// - soft-stop ramps target down over 2.8ms
// - discharge after soft-stop if protected, until run
// - fault soft-stop: high gate off, low after
// - protected overvoltage latches low gate, shuts all
// - reference follows main ramp during soft-stop
// - standby disables termination, keeps reference
`timescale 1ns/1ns
`include "seq_consts.svh"
module ddr_supply_fault_sequencer
  import seq_pkg::*;
#(
  parameter int unsigned SOFT_START_CYC = `SOFT_START_CYC,
  parameter int unsigned SOFT_STOP_CYC = `SOFT_STOP_CYC,
  parameter int unsigned TERM_RAMP_CYC = `TERM_RAMP_CYC,
  parameter int unsigned UV_PERSIST_CYC = `UV_PERSIST_CYC,
  parameter int unsigned TERM_PERSIST_CYC = `TERM_PERSIST_CYC
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // system controller selects (pins)
  input wire logic run_request,
  input wire logic overvolt_protect_select,
  input wire logic standby_select,
  input wire logic forced_continuous_switching,
  // bias comparators (pins)
  input wire logic bias_por_ok,
  input wire logic bias_lockout,
  input wire logic reference_valid,
  // analog comparators (pins)
  input wire logic valley_over,
  input wire logic negative_over,
  input wire logic main_in_window,
  input wire logic main_over,
  input wire logic main_under,
  input wire logic term_in_window,
  input wire logic thermal_fault,
  // gate drive
  output logic high_side_gate,
  output logic low_side_gate,
  output logic switch_allow,
  output logic pulse_skip,
  // open-drain good flags: enable high pulls the pin low
  output logic main_output_good_flag_o,
  output logic main_output_good_flag_oe,
  output logic term_output_good_flag_o,
  output logic term_output_good_flag_oe,
  // regulator enables and limits
  output logic term_enable,
  output logic ref_enable,
  output logic [`RAMP_W-1:0] main_target,
  output logic [`RAMP_W-1:0] ref_target,
  output logic [`RAMP_W-1:0] term_current_limit,
  // discharge switches
  output logic main_discharge,
  output logic term_discharge,
  // status
  output logic converter_running_ok,
  output logic fault_latched
);
  localparam int unsigned NS = 14; // synchronised input count

  typedef struct packed {
    logic [NS-1:0] meta;
    logic [NS-1:0] sync;
    logic run_prev;
    logic por_prev;
    logic lock_prev;
    seq_state_t st;
    logic fault;
    logic ov_latched;
    logic fault_stop;
    logic discharge;
    logic [31:0] uv_cnt;
    logic [31:0] tf_cnt;
    drive_t drv;
    logic [`RAMP_W-1:0] target;
    logic [`RAMP_W-1:0] ilim;
    logic runok;
  } top_state_t;
  top_state_t s_q, s_d;

  // synchronised aliases
  logic run_s, ovp_s, stby_s, fcs_s, por_s, lock_s, reference_valid_s;
  sense_t sn;
  // ramp counter hooks
  logic ss_start, ss_done, sd_start, sd_done, tr_start, tr_done;
  logic [`RAMP_W-1:0] ss_level, sd_level, tr_level;
  logic ramp_clear;

  assign {run_s, ovp_s, stby_s, fcs_s, por_s, lock_s, reference_valid_s} = s_q.sync[NS-1:7];
  // low seven bits follow the sense_t field order, thermal last
  assign sn = s_q.sync[6:0];

  // soft-start, soft-stop and term limit ramps
  ramp_counter #(.COUNT(SOFT_START_CYC)) u_ss (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .start(ss_start), .clear(ramp_clear), .done(ss_done), .level(ss_level));
  ramp_counter #(.COUNT(SOFT_STOP_CYC)) u_sd (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .start(sd_start), .clear(ramp_clear), .done(sd_done), .level(sd_level));
  ramp_counter #(.COUNT(TERM_RAMP_CYC)) u_tr (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .start(tr_start), .clear(ramp_clear), .done(tr_done), .level(tr_level));

  // sequencing and supervision, one pass per clock
  always_comb begin
    logic run_rise, run_fall, por_rise, lock_fall, hard_off, ov_hit;
    logic stop_req;
    s_d = s_q;
    run_rise = 1'b0;
    run_fall = 1'b0;
    por_rise = 1'b0;
    lock_fall = 1'b0;
    hard_off = 1'b0;
    ov_hit = 1'b0;
    stop_req = 1'b0;
    ss_start = 1'b0;
    sd_start = 1'b0;
    tr_start = 1'b0;
    ramp_clear = 1'b0;
    // two-flop synchronisers; only the second stage is read
    s_d.meta = {run_request, overvolt_protect_select, standby_select,
                forced_continuous_switching, bias_por_ok, bias_lockout,
                reference_valid, valley_over, negative_over, main_in_window,
                main_over, main_under, term_in_window, thermal_fault};
    s_d.sync = s_q.meta;
    s_d.run_prev = run_s;
    s_d.por_prev = por_s;
    s_d.lock_prev = lock_s;
    run_rise = run_s & ~s_q.run_prev;
    run_fall = ~run_s & s_q.run_prev;
    por_rise = por_s & ~s_q.por_prev;
    lock_fall = ~lock_s & s_q.lock_prev;
    ov_hit = sn.main_over;
    // bias below reset level: everything off, latch cleared
    if (!por_s) begin
      s_d.st = st_off;
      s_d.fault = 1'b0;
      s_d.ov_latched = 1'b0;
      s_d.discharge = 1'b0;
      ramp_clear = 1'b1;
      hard_off = 1'b1;
    end else if (por_rise) begin
      s_d.fault = 1'b0;
      s_d.ov_latched = 1'b0;
      s_d.discharge = ovp_s;
      s_d.st = st_off;
      ramp_clear = 1'b1;
      hard_off = 1'b1;
    end else if (!lock_s) begin
      // lockout: stop at once, discharge only when protected
      s_d.st = st_wait_bias;
      if (lock_fall) begin
        s_d.discharge = ovp_s;
      end
      ramp_clear = 1'b1;
      hard_off = 1'b1;
    end else if (ov_hit && ovp_s && s_q.st != st_off) begin
      // protected overvoltage latches immediately
      s_d.ov_latched = 1'b1;
      s_d.fault = 1'b1;
      s_d.discharge = 1'b1;
      s_d.st = st_latched;
      ramp_clear = 1'b1;
    end else begin
      // persistence timers
      if (s_q.st == st_run && sn.main_under) begin
        s_d.uv_cnt = s_q.uv_cnt + 32'h1;
      end else begin
        s_d.uv_cnt = '0;
      end
      if (s_q.st == st_run && !stby_s && !s_q.drv.term_output_good_flag_oe == 1'b0
          && !sn.term_in_window) begin
        s_d.tf_cnt = s_q.tf_cnt + 32'h1;
      end else begin
        s_d.tf_cnt = '0;
      end
      stop_req = run_fall | sn.thermal
               | (s_q.uv_cnt >= 32'(UV_PERSIST_CYC))
               | (s_q.tf_cnt >= 32'(TERM_PERSIST_CYC));
      unique case (s_q.st)
        st_off, st_wait_bias: begin
          // rising run or lockout release starts soft-start
          if (run_s && reference_valid_s && (run_rise || s_q.st == st_wait_bias || !s_q.fault)
              && !(s_q.fault && !run_rise)) begin
            s_d.st = st_soft_start;
            s_d.fault = 1'b0;
            s_d.ov_latched = 1'b0;
            s_d.discharge = 1'b0;
            s_d.fault_stop = 1'b0;
            ss_start = 1'b1;
          end
        end
        st_soft_start: begin
          if (stop_req) begin
            s_d.st = st_soft_stop;
            s_d.fault_stop = ~run_fall & ~sn.thermal;
            s_d.fault = ~run_fall;
            sd_start = 1'b1;
          end else if (ss_done) begin
            s_d.st = st_run;
            tr_start = ~stby_s;
          end
        end
        st_run: begin
          if (stop_req) begin
            s_d.st = st_soft_stop;
            s_d.fault_stop = ~run_fall & ~sn.thermal;
            s_d.fault = ~run_fall;
            sd_start = 1'b1;
          end else if (stby_s) begin
            ramp_clear = 1'b0;
          end else if (!s_q.drv.term_enable) begin
            tr_start = 1'b1; // leaving standby restarts limit ramp
          end
        end
        st_soft_stop: begin
          if (sd_done) begin
            s_d.st = s_q.fault ? st_latched : st_off;
            s_d.discharge = ovp_s;
          end
        end
        st_latched: begin
          // held until run toggles
          if (run_fall) begin
            s_d.st = st_off;
            s_d.fault = 1'b0;
          end
        end
        default: begin
          s_d.st = st_off;
        end
      endcase
    end
    // drive outputs from next state
    s_d.drv = '0;
    s_d.drv.ref_enable = 1'b1;
    s_d.target = '0;
    s_d.ilim = '0;
    s_d.runok = 1'b0;
    s_d.drv.main_discharge = s_d.discharge;
    s_d.drv.term_discharge = s_d.discharge;
    s_d.drv.main_output_good_flag_oe = 1'b1;
    s_d.drv.term_output_good_flag_oe = 1'b1;
    s_d.drv.pulse_skip = 1'b1;
    if (!hard_off) begin
      unique case (s_d.st)
        st_soft_start: begin
          s_d.drv.switch_allow = ~sn.valley_over;
          s_d.drv.term_enable = 1'b0;
          s_d.target = ss_level;
          s_d.drv.high_side_gate = ~sn.valley_over;
          s_d.drv.low_side_gate = sn.valley_over;
        end
        st_run: begin
          s_d.runok = 1'b1;
          s_d.target = `RAMP_FULL;
          s_d.drv.pulse_skip = ~fcs_s | stby_s;
          // valley limit blocks high side; negative limit in continuous
          s_d.drv.switch_allow = ~sn.valley_over & ~(fcs_s & ~stby_s & sn.negative_over);
          s_d.drv.high_side_gate = s_d.drv.switch_allow;
          s_d.drv.low_side_gate = ~s_d.drv.switch_allow;
          s_d.drv.main_output_good_flag_oe = ~sn.main_in_window | ov_hit;
          s_d.drv.term_enable = ~stby_s;
          s_d.ilim = (tr_done | sn.term_in_window) ? `RAMP_FULL : tr_level;
          s_d.drv.term_output_good_flag_oe = stby_s | ~sn.term_in_window;
        end
        st_soft_stop: begin
          s_d.target = `RAMP_FULL - sd_level;
          s_d.drv.pulse_skip = 1'b0;
          // next-state flag, so the entry cycle keeps the high side off too
          s_d.drv.high_side_gate = ~s_d.fault_stop;
          s_d.drv.low_side_gate = 1'b1;
          s_d.drv.term_enable = ~stby_s;
          s_d.ilim = `RAMP_FULL;
        end
        st_latched: begin
          s_d.drv.low_side_gate = s_q.ov_latched | s_d.ov_latched;
          s_d.drv.ref_enable = ~s_d.ov_latched;
        end
        default: begin
          s_d.drv.ref_enable = 1'b1;
        end
      endcase
    end else begin
      s_d.drv.ref_enable = 1'b0;
    end
  end

  // single state register, frozen by clk_en
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register; flag data pins tied low
  assign high_side_gate = s_q.drv.high_side_gate;
  assign low_side_gate = s_q.drv.low_side_gate;
  assign switch_allow = s_q.drv.switch_allow;
  assign pulse_skip = s_q.drv.pulse_skip;
  assign main_output_good_flag_o = 1'b0;
  assign main_output_good_flag_oe = s_q.drv.main_output_good_flag_oe;
  assign term_output_good_flag_o = 1'b0;
  assign term_output_good_flag_oe = s_q.drv.term_output_good_flag_oe;
  assign term_enable = s_q.drv.term_enable;
  assign ref_enable = s_q.drv.ref_enable; // enabled at once; ref_target still ramps with main
  assign main_target = s_q.target;
  assign ref_target = s_q.target; // reference tracks main ramp
  assign term_current_limit = s_q.ilim;
  assign main_discharge = s_q.drv.main_discharge;
  assign term_discharge = s_q.drv.term_discharge;
  assign converter_running_ok = s_q.runok;
  assign fault_latched = s_q.fault;

  // flags held low while not running
  good_low_a: assert property (@(posedge clock) disable iff (sys_rst)
    (s_q.st != st_run && !$past(sys_rst))
    |-> (main_output_good_flag_oe && term_output_good_flag_oe))
    else $error("good flag released outside run");
  hs_block_a: assert property (@(posedge clock) disable iff (sys_rst)
    (s_q.st == st_run && $past(sn.valley_over) && clk_en && $past(clk_en))
    |-> !switch_allow || !$past(sn.valley_over))
    else $error("high side allowed over valley limit");
  lock_off_a: assert property (@(posedge clock) disable iff (sys_rst)
    (por_s && !lock_s) |=> (!high_side_gate && !low_side_gate && !term_enable))
    else $error("outputs active under lockout");
  fault_stop_a: assert property (@(posedge clock) disable iff (sys_rst)
    (s_q.st == st_soft_stop && s_q.fault_stop) |-> !high_side_gate)
    else $error("high side on in fault soft-stop");
  stby_term_a: assert property (@(posedge clock) disable iff (sys_rst)
    (s_q.st == st_run && stby_s && $past(stby_s)) |-> !term_enable || !clk_en)
    else $error("termination on in standby");
  skip_start_a: assert property (@(posedge clock) disable iff (sys_rst)
    (s_q.st == st_soft_start) |-> pulse_skip)
    else $error("not skipping during soft-start");
  ovp_latch_a: assert property (@(posedge clock) disable iff (sys_rst)
    (s_q.ov_latched && s_q.st == st_latched) |-> (low_side_gate && main_discharge))
    else $error("overvoltage latch not driving");
  ref_track_a: assert property (@(posedge clock) disable iff (sys_rst)
    ref_target == main_target)
    else $error("reference not tracking main");
endmodule

// ===== tb/sys_ctrl_model.sv
/*
  sys_ctrl_model: the system controller and bias monitor that drive the
  run, select and bias pins of the sequencer.
  assumes the bench calls set_pins; pins move only just after a rising edge.
*/
`timescale 1ns/1ns
module sys_ctrl_model (
  // clock
  input wire logic clock,
  // pins toward the sequencer
  output logic run_request,
  output logic overvolt_protect_select,
  output logic standby_select,
  output logic forced_continuous_switching,
  output logic bias_por_ok,
  output logic bias_lockout,
  output logic reference_valid
);
  // unpowered and idle at time zero
  initial begin
    {run_request, overvolt_protect_select, standby_select} = 3'h0;
    {forced_continuous_switching, bias_por_ok, bias_lockout, reference_valid} = 4'h0;
  end
  // lag lets a slow controller wait some cycles before its pins move
  task automatic set_pins(input logic [6:0] pins, input int lag);
    repeat (lag) @(posedge clock);
    @(posedge clock);
    {run_request, overvolt_protect_select, standby_select, forced_continuous_switching,
     bias_por_ok, bias_lockout, reference_valid} <= pins;
  endtask
endmodule

// ===== tb/ddr_supply_fault_sequencer_test.sv
/*
  testbench for the supply fault sequencer: one hand-written task a scenario.
  assumes shortened timing parameters and a pull-up on both good flags.
*/
`timescale 1ns/1ns
`include "seq_consts.svh"
module ddr_supply_fault_sequencer_test;
  import seq_pkg::*;
  localparam int SS = 20; // soft-start cycles
  localparam int SD = 40; // soft-stop cycles
  localparam sense_t OK = 7'h12; // both outputs in window, no fault
  logic clock, sys_rst;
  sense_t sense; // comparator pins
  int errors, comparisons, n;
  logic hs_seen; // any high-side pulse seen in a span
  logic [7:0] r; // earlier reference level
  logic run_request, overvolt_protect_select, standby_select, forced_continuous_switching;
  logic bias_por_ok, bias_lockout, reference_valid;
  logic high_side_gate, low_side_gate, switch_allow, pulse_skip;
  logic main_o, main_oe, term_o, term_oe;
  logic term_enable, ref_enable, main_discharge, term_discharge;
  logic converter_running_ok, fault_latched;
  logic [`RAMP_W-1:0] main_target, ref_target, term_current_limit;
  // open-drain flags read through a pull-up
  wire main_pin = main_oe ? main_o : 1'b1;
  wire term_pin = term_oe ? term_o : 1'b1;

  ddr_supply_fault_sequencer #(.SOFT_START_CYC(SS), .SOFT_STOP_CYC(SD), .TERM_RAMP_CYC(8),
    .UV_PERSIST_CYC(5), .TERM_PERSIST_CYC(10)) i_dut (
    .clock, .sys_rst, .clk_en(1'b1), .run_request, .overvolt_protect_select,
    .standby_select, .forced_continuous_switching, .bias_por_ok, .bias_lockout,
    .reference_valid, .valley_over(sense.valley_over), .negative_over(sense.negative_over),
    .main_in_window(sense.main_in_window), .main_over(sense.main_over),
    .main_under(sense.main_under), .term_in_window(sense.term_in_window),
    .thermal_fault(sense.thermal), .high_side_gate, .low_side_gate, .switch_allow,
    .pulse_skip, .main_output_good_flag_o(main_o), .main_output_good_flag_oe(main_oe),
    .term_output_good_flag_o(term_o), .term_output_good_flag_oe(term_oe), .term_enable,
    .ref_enable, .main_target, .ref_target, .term_current_limit, .main_discharge,
    .term_discharge, .converter_running_ok, .fault_latched);
  sys_ctrl_model i_ctrl (.clock, .run_request, .overvolt_protect_select, .standby_select,
    .forced_continuous_switching, .bias_por_ok, .bias_lockout, .reference_valid);

  // free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  // sample on falling edges, clear of the launch edge
  task automatic tick(input int k);
    repeat (k) @(negedge clock);
  endtask
  // controller pins with power-on bias and reference good, lockout as given; wait past the sync delay
  task automatic pins(input logic run, prot, stby, fcm, lock, input int lag = 0);
    i_ctrl.set_pins({run, prot, stby, fcm, 1'b1, lock, 1'b1}, lag);
    tick(6);
  endtask
  // new comparator results
  task automatic feel(input sense_t v);
    @(posedge clock);
    sense <= v;
    tick(6);
  endtask
  task automatic end_sim;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic t_idle;
    pins(0, 0, 0, 1, 0);
    check(switch_allow, 0, "switching before lockout clears");
    check(main_pin, 0, "main flag in shutdown");
    check(term_pin, 0, "term flag in shutdown");
  endtask
  // run rise with a slow controller, then the settled run state
  task automatic t_start(input logic prot);
    pins(0, prot, 0, 1, 1);
    feel(OK);
    pins(1, prot, 0, 1, 1, 2);
    check(pulse_skip, 1, "skip during soft-start");
    check(main_pin, 0, "main flag in soft-start");
    check(term_pin, 0, "term flag in soft-start");
    check(ref_enable, 1, "reference up at once");
    for (n = 6; converter_running_ok !== 1'b1 && n < 99; n++) tick(1);
    check(n >= SS && n <= SS + 10, 1, "soft-start length");
    check(main_target, 8'hFF, "target at full scale");
    tick(6);
    check(pulse_skip, 0, "forced continuous after start");
    check({main_pin, term_pin}, 2'b11, "flags released");
    check(term_current_limit, 8'hFF, "term limit full");
    check({main_discharge, fault_latched}, 0, "discharge and latch clear");
  endtask
  task automatic t_running;
    feel(7'h02);
    check(main_pin, 0, "main flag out of window");
    feel(7'h1A);
    check(main_pin, 0, "overvoltage drops main flag");
    check({fault_latched, converter_running_ok}, 2'b01, "unprotected keeps running");
    feel(7'h52);
    hs_seen = 1'b0;
    repeat (20) begin
      tick(1);
      hs_seen |= high_side_gate;
    end
    check(hs_seen, 0, "no cycle above valley limit");
    feel(7'h32);
    check(switch_allow, 0, "negative limit in forced continuous");
    feel(OK);
    check(main_pin, 1, "main flag back in window");
    pins(1, 0, 1, 1, 1);
    check({term_enable, ref_enable}, 2'b01, "standby drops term only");
    check(term_pin, 0, "term flag in standby");
    pins(1, 0, 0, 1, 1);
    check(term_enable, 1, "term back from standby");
  endtask
  task automatic t_lockout(input logic prot);
    pins(1, prot, 0, 1, 0);
    check({high_side_gate, low_side_gate}, 0, "gates low on lockout");
    check({main_pin, term_pin, term_enable, ref_enable}, 0, "flags, regulators off");
    check({main_discharge, term_discharge}, {prot, prot}, "lockout discharge");
    pins(0, prot, 0, 1, 1);
  endtask
  task automatic t_stop;
    pins(0, 1, 0, 1, 1);
    check(main_pin, 0, "main flag in soft-stop");
    r = ref_target;
    tick(4);
    check(ref_target < r && ref_target != 8'h00, 1, "reference ramps down");
    for (n = 10; main_target !== 8'h00 && n < 99; n++) tick(1);
    check(n >= SD && n <= SD + 10, 1, "soft-stop length");
    tick(4);
    check({main_discharge, term_discharge}, 2'b11, "discharge after stop");
  endtask
  task automatic t_term_fault;
    feel(7'h10);
    check(term_pin, 0, "term flag out of band");
    for (n = 6; fault_latched !== 1'b1 && n < 99; n++) tick(1);
    check(n >= 10 && n <= 22, 1, "term fault persistence");
    check({main_pin, term_pin}, 0, "fault drops both flags");
    hs_seen = 1'b0;
    for (n = 0; main_target !== 8'h00 && n < 99; n++) begin
      tick(1);
      hs_seen |= high_side_gate;
    end
    check(hs_seen, 0, "high gate off in fault stop");
    tick(4);
    check({low_side_gate, main_discharge}, 2'b01, "low gate off, discharge on");
    feel(OK);
    pins(1, 1, 0, 1, 1);
    check(converter_running_ok, 0, "latched until run toggles");
  endtask
  task automatic t_prot_over;
    feel(7'h1A);
    check({high_side_gate, low_side_gate}, 2'b01, "low gate latched high");
    check({main_pin, term_pin, term_enable}, 0, "flags and term off");
    check({main_discharge, term_discharge, fault_latched}, 3'h7, "discharge, latch");
    feel(OK);
    check(low_side_gate, 1, "low gate stays latched");
    // bias collapses, then only the power-on level returns
    i_ctrl.set_pins(7'h61, 0);
    tick(6);
    i_ctrl.set_pins(7'h65, 0);
    tick(6);
    check(fault_latched, 0, "power-on reset clears latch");
    check({main_discharge, term_discharge}, 2'b11, "discharge on power-on");
  endtask

  // main sequence
  initial begin
    errors = 0;
    comparisons = 0;
    sense = OK;
    sys_rst = 1'b1;
    tick(6);
    check({main_oe, term_oe, term_enable}, 0, "outputs idle in reset");
    @(posedge clock);
    sys_rst <= 1'b0;
    t_idle;
    t_start(0);
    t_running;
    t_lockout(0);
    t_start(1);
    t_stop;
    t_start(1);
    t_lockout(1);
    t_start(1);
    t_term_fault;
    t_start(1);
    t_prot_over;
    end_sim;
  end
  // the scenarios take well under 2000 cycles
  initial begin
    #50000;
    errors++;
    end_sim;
  end
endmodule
